// ### logic/alr_pkg.sv
// package for the atomic lock reservation unit
package alr_pkg;
  // configuration codes
  localparam logic [1:0] ALR_CFG_SINGLE = 2'h0;
  localparam logic [1:0] ALR_CFG_MULTI_CORE = 2'h1;
  localparam logic [1:0] ALR_CFG_MULTI_THREAD = 2'h2;
  // operation codes
  localparam logic [2:0] ALR_OP_NONE = 3'h0;
  localparam logic [2:0] ALR_OP_LINKED_LOAD = 3'h1;
  localparam logic [2:0] ALR_OP_COND_STORE = 3'h2;
  localparam logic [2:0] ALR_OP_STORE = 3'h3;
  localparam logic [2:0] ALR_OP_WAIT_LOCK = 3'h4;
  localparam logic [2:0] ALR_OP_WRITE_BARRIER = 3'h5;
  localparam logic [2:0] ALR_OP_DI_BARRIER = 3'h6;
  localparam logic [2:0] ALR_OP_RET_INT = 3'h7;
  // address layout: 32-byte line, tag in upper bits
  localparam int ALR_LINE_LSB = 5;
  localparam int ALR_TAG_W = 32 - ALR_LINE_LSB;
  localparam logic [ALR_TAG_W-1:0] ALR_TAG_RST = 27'h0;
  localparam logic ALR_LOCK_RST = 1'b0;
  // peers seen on the coherency side
  localparam int ALR_PEERS = 4;
  // request from the load/store pipeline
  typedef struct packed {
    logic valid;
    logic [2:0] op;
    logic [31:0] vaddr;
    logic [31:0] paddr;
    logic ctrl_space;
    logic ctrl_unmapped;
    logic xlate_fault;
    logic [31:0] wdata;
  } alr_req_t;
  // answer to the pipeline
  typedef struct packed {
    logic done;
    logic [31:0] rdata;
    logic branch_val;
    logic mem_write;
    logic exc_violation;
    logic exc_unmapped;
  } alr_rsp_t;
  typedef enum logic [1:0] {
    ALR_IDLE,
    ALR_WAIT_LOCK,
    ALR_WMB,
    ALR_DIB
  } alr_state_t;
endpackage

// ### logic/alr_unit.sv
// atomic lock reservation unit for one core or hardware thread
// Operation
// - control-space linked ops raise violation, no lock
// - conditional store tests lock after checks pass
// - multi configs record linked-load physical address
// - linked load returns word, sets lock
// - set lock: store happens, branch true
// - multi-core success clears matching peer locks
// - multi-thread success clears matching other threads
// - clear lock: no write, branch false
// - conditional store that passes checks always clears local lock
// - success depends on lock flag only
// - plain control-space store: violation or unmapped
// - multi-core store clears matching peer locks
// - multi-thread store clears other matching threads
// - single-core store leaves lock unchanged
// - multi-core wait stalls while lock set
// - multi-thread wait deschedules while lock set
// - single-core wait is a no-op
// - multi-core write barrier waits acks and flush
// - other configs write barrier is no-op
// - di barrier makes data writes visible
// - di barrier sends writes; multi-core also waits for acks
// - translated address readable in reservation register
// - single-core reservation address field reads zero
// - lock address aligned to 32-byte line
// - trap entry clears local lock
// - debug mirror lock not cleared on trap
`timescale 1ns/1ps
module alr_unit
  import alr_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic [1:0] CFG_I,
  input wire alr_req_t REQ_I,
  input wire logic [31:0] LOAD_DATA_I,
  input wire logic TRAP_I,
  input wire logic IRQ_I,
  input wire logic SNOOP_VALID_I,
  input wire logic [31:0] SNOOP_ADDR_I,
  input wire logic WB_EMPTY_I,
  input wire logic COH_ACK_DONE_I,
  output logic [ALR_PEERS-1:0] PEER_CLEAR_O,
  output logic [31:0] PEER_CLEAR_ADDR_O,
  output alr_rsp_t RSP_O,
  output logic STALL_O,
  output logic DESCHED_O,
  output logic FLUSH_O,
  output logic DI_SYNC_O,
  output logic LOCK_O,
  output logic SHADOW_LOCK_O,
  output logic [31:0] RES_ADDR_O
);
  // --------------------------------------------------------------
  // decode
  // --------------------------------------------------------------
  logic lock_q, lock_d, shadow_q, shadow_d;
  logic [ALR_TAG_W-1:0] tag_q, tag_d;
  alr_state_t st_q, st_d;
  alr_rsp_t rsp_q, rsp_d;
  logic stall_q, desched_q, flush_q, dis_q;
  logic [ALR_PEERS-1:0] pclr_q;
  logic [31:0] paddr_q;
  wire is_mc = (CFG_I == ALR_CFG_MULTI_CORE);
  wire is_mt = (CFG_I == ALR_CFG_MULTI_THREAD);
  wire is_multi = is_mc | is_mt;
  wire idle = (st_q == ALR_IDLE);
  wire go = REQ_I.valid & idle;
  wire op_ll = go & (REQ_I.op == ALR_OP_LINKED_LOAD);
  wire op_sc = go & (REQ_I.op == ALR_OP_COND_STORE);
  wire op_st = go & (REQ_I.op == ALR_OP_STORE);
  wire op_wl = go & (REQ_I.op == ALR_OP_WAIT_LOCK);
  wire op_wb = go & (REQ_I.op == ALR_OP_WRITE_BARRIER);
  wire op_di = go & (REQ_I.op == ALR_OP_DI_BARRIER);
  wire op_rfi = go & (REQ_I.op == ALR_OP_RET_INT);
  // linked ops in control space always violate
  wire lk_viol = (op_ll | op_sc) & REQ_I.ctrl_space;
  // plain store takes the control space map answer
  wire st_viol = op_st & REQ_I.ctrl_space & ~REQ_I.ctrl_unmapped;
  wire st_unmap = op_st & REQ_I.ctrl_space & REQ_I.ctrl_unmapped;
  wire ll_ok = op_ll & ~REQ_I.ctrl_space & ~REQ_I.xlate_fault;
  wire sc_ok = op_sc & ~REQ_I.ctrl_space & ~REQ_I.xlate_fault;
  wire st_ok = op_st & ~REQ_I.ctrl_space & ~REQ_I.xlate_fault;
  // success uses the flag only, address ignored
  wire sc_win = sc_ok & lock_q;
  // remote store to our line, coherency side
  wire snoop_hit = SNOOP_VALID_I & is_multi &
    (SNOOP_ADDR_I[31:ALR_LINE_LSB] == tag_q);
  // stores that clear matching peer locks
  wire bcast = is_multi & (st_ok | sc_win);

  // --------------------------------------------------------------
  // lock events
  // --------------------------------------------------------------
  // local set by a clean linked load
  wire lock_set = ll_ok;
  // local clear by conditional store or return
  wire local_clr = sc_ok | op_rfi;
  // remote clear by a store to our line
  wire remote_clr = snoop_hit;
  // trap clears the lock but not the mirror
  wire trap_clr = TRAP_I;
  // new reservation line, multi configs only
  wire tag_load = ll_ok & is_multi;

  // --------------------------------------------------------------
  // lock flag, shadow and reservation address
  // --------------------------------------------------------------
  // clears beat a set falling in the same cycle
  always_comb begin
    lock_d = lock_q;
    shadow_d = shadow_q;
    tag_d = tag_q;
    if (lock_set) begin
      lock_d = 1'b1;
      shadow_d = 1'b1;
    end
    if (tag_load) begin
      tag_d = REQ_I.paddr[31:ALR_LINE_LSB];
    end
    if (remote_clr | local_clr) begin
      lock_d = 1'b0;
      shadow_d = 1'b0;
    end
    if (trap_clr) begin
      lock_d = 1'b0;
    end
  end

  // --------------------------------------------------------------
  // sequencing of wait and barriers
  // --------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q)
      // idle: wait only holds while the lock is set
      ALR_IDLE: begin
        if (op_wl & lock_q & is_multi) begin
          st_d = ALR_WAIT_LOCK;
        end else if (op_wb & is_mc) begin
          st_d = ALR_WMB;
        end else if (op_di) begin
          st_d = ALR_DIB;
        end
      end
      // wait: clear lock, interrupt or trap ends it
      ALR_WAIT_LOCK: begin
        if (~lock_q | IRQ_I | TRAP_I) begin
          st_d = ALR_IDLE;
        end
      end
      // write barrier: drained buffer and acks
      ALR_WMB: begin
        if (WB_EMPTY_I & COH_ACK_DONE_I) begin
          st_d = ALR_IDLE;
        end
      end
      ALR_DIB: begin
        // multi-core waits for acks, others only for issue
        if (WB_EMPTY_I & (~is_mc | COH_ACK_DONE_I)) begin
          st_d = ALR_IDLE;
        end
      end
      default: st_d = ALR_IDLE;
    endcase
  end

  // --------------------------------------------------------------
  // answer to the pipeline
  // --------------------------------------------------------------
  wire leave = ~idle & (st_d == ALR_IDLE);
  wire quick = go & ~(st_d != ALR_IDLE);
  // violation covers linked ops and mapped stores
  wire exc_viol_d = lk_viol | st_viol;
  // memory written by a clean store or a winner
  wire mem_wr_d = sc_win | st_ok;
  // loaded word only for a clean linked load
  wire [31:0] rdata_d = ll_ok ? LOAD_DATA_I : 32'h0;
  // one-cycle answer, all fields zero otherwise
  always_comb begin
    rsp_d = '0;
    rsp_d.done = quick | leave;
    rsp_d.exc_violation = exc_viol_d;
    rsp_d.exc_unmapped = st_unmap;
    rsp_d.rdata = rdata_d;
    rsp_d.branch_val = sc_win;
    rsp_d.mem_write = mem_wr_d;
  end

  // --------------------------------------------------------------
  // next values of the pipeline holds, barrier outputs and peer clear
  // --------------------------------------------------------------
  wire in_wait = (st_d == ALR_WAIT_LOCK);
  wire in_wmb = (st_d == ALR_WMB);
  wire in_dib = (st_d == ALR_DIB);
  // multi-core wait and both barriers freeze the pipeline
  wire stall_d = in_wmb | in_dib | (in_wait & ~is_mt);
  // multi-thread wait parks the thread instead
  wire desched_d = in_wait & is_mt;
  // write buffer drains during either barrier
  wire flush_d = in_wmb | in_dib;
  wire dis_d = in_dib;
  // clear pulse to every peer on a store, multi configs only
  wire [ALR_PEERS-1:0] pclr_d = {ALR_PEERS{bcast}};

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  // lock flag, mirror and reservation line
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      lock_q <= ALR_LOCK_RST;
      shadow_q <= ALR_LOCK_RST;
      tag_q <= ALR_TAG_RST;
    end else begin
      lock_q <= lock_d;
      shadow_q <= shadow_d;
      tag_q <= tag_d;
    end
  end

  // sequencer state
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      st_q <= ALR_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // registered answer to the pipeline
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

  // peer clear pulse
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      pclr_q <= '0;
    end else begin
      pclr_q <= pclr_d;
    end
  end

  // address sent along with the clear
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      paddr_q <= 32'h0;
    end else begin
      paddr_q <= REQ_I.paddr;
    end
  end

  // pipeline holds
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      stall_q <= 1'b0;
      desched_q <= 1'b0;
    end else begin
      stall_q <= stall_d;
      desched_q <= desched_d;
    end
  end

  // barrier outputs
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      flush_q <= 1'b0;
      dis_q <= 1'b0;
    end else begin
      flush_q <= flush_d;
      dis_q <= dis_d;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  // answer and peer traffic
  assign RSP_O = rsp_q;
  assign PEER_CLEAR_O = pclr_q;
  assign PEER_CLEAR_ADDR_O = paddr_q;
  // pipeline holds and barrier status
  assign STALL_O = stall_q;
  assign DESCHED_O = desched_q;
  assign FLUSH_O = flush_q;
  assign DI_SYNC_O = dis_q;
  // lock state
  assign LOCK_O = lock_q;
  assign SHADOW_LOCK_O = shadow_q;
  // single-core build shows a zero address field
  assign RES_ADDR_O = {tag_q, 4'h0, shadow_q};
endmodule // alr_unit

// ### tb/alr_checker.sv
// port assertions for the lock reservation unit
`timescale 1ns/1ps
module alr_checker
  import alr_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic [1:0] CFG_I,
  input wire alr_req_t REQ_I,
  input wire logic TRAP_I,
  input wire logic IRQ_I,
  input wire logic SNOOP_VALID_I,
  input wire logic [ALR_PEERS-1:0] PEER_CLEAR_O,
  input wire logic [31:0] PEER_CLEAR_ADDR_O,
  input wire alr_rsp_t RSP_O,
  input wire logic STALL_O,
  input wire logic DESCHED_O,
  input wire logic FLUSH_O,
  input wire logic LOCK_O,
  input wire logic [31:0] RES_ADDR_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  // taken request with no competing clear
  wire tk = REQ_I.valid && !STALL_O && !DESCHED_O && !FLUSH_O
    && !TRAP_I && !SNOOP_VALID_I;
  wire ok = !REQ_I.ctrl_space && !REQ_I.xlate_fault;
  wire mul = CFG_I != ALR_CFG_SINGLE;
  wire ll = tk && REQ_I.op == ALR_OP_LINKED_LOAD;
  wire cs = tk && REQ_I.op == ALR_OP_COND_STORE;
  sequence s_wait;
    tk && REQ_I.op == ALR_OP_WAIT_LOCK && LOCK_O && !IRQ_I && mul;
  endsequence
  AST_LL: assert property (ll && ok |=> LOCK_O && RSP_O.done)
    else $error("linked load left lock clear");
  AST_RES: assert property (ll && ok |=> RES_ADDR_O[31:5] ==
    (mul ? $past(REQ_I.paddr[31:5]) : 27'h0))
    else $error("reservation address wrong");
  AST_CTRL: assert property ((ll || cs) && REQ_I.ctrl_space |=>
    RSP_O.exc_violation && LOCK_O == $past(LOCK_O))
    else $error("control space linked op misbehaved");
  AST_CS_CLR: assert property (cs && ok |=> !LOCK_O)
    else $error("lock kept after conditional store");
  AST_CS_BR: assert property (cs && ok |=>
    RSP_O.branch_val == $past(LOCK_O) && RSP_O.mem_write == $past(LOCK_O))
    else $error("conditional store result wrong");
  AST_PEER: assert property (cs && ok && LOCK_O && mul |=>
    PEER_CLEAR_O == '1 && PEER_CLEAR_ADDR_O == $past(REQ_I.paddr))
    else $error("peer clear missing");
  AST_SSTORE: assert property (tk && REQ_I.op == ALR_OP_STORE && !mul
    |=> LOCK_O == $past(LOCK_O))
    else $error("single core store changed lock");
  AST_TRAP: assert property (TRAP_I |=> !LOCK_O)
    else $error("trap left lock set");
  AST_WAIT: assert property (s_wait |=>
    (CFG_I == ALR_CFG_MULTI_CORE ? STALL_O : DESCHED_O))
    else $error("wait did not hold the pipeline");
endmodule // alr_checker

// ### tb/alr_peer_model.sv
// coherency side: write buffer drain and broadcast acks
`timescale 1ns/1ps
module alr_peer_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  output logic wb_empty_o,
  output logic ack_done_o
);
  logic [1:0] cnt_q;
  // answers three cycles into a flush
  always_ff @(posedge clk_i) begin
    if (rst_i || !flush_i) cnt_q <= 2'h0;
    else if (cnt_q != 2'h3) cnt_q <= cnt_q + 2'h1;
  end
  assign wb_empty_o = cnt_q == 2'h3;
  assign ack_done_o = cnt_q == 2'h3;
endmodule // alr_peer_model

// ### tb/test_alr_unit.sv
// testbench for the lock reservation unit
`timescale 1ns/1ps
module test_alr_unit import alr_pkg::*;;
  logic clk = 1'b0, rst = 1'b1, trap = 1'b0, irq = 1'b0, snp = 1'b0, d;
  logic [1:0] cfg = ALR_CFG_SINGLE;
  logic [31:0] snp_a = 32'h0, pca, res;
  alr_req_t req = '0;
  alr_rsp_t rsp;
  logic wbe, ack, flush, dis, stall, dsch, lock, shd;
  logic [ALR_PEERS-1:0] pclr;
  int err_count = 0, checks = 0;
  always #50 clk = ~clk;
  alr_unit dut (.SYS_CLK_I(clk), .RST_I(rst), .CFG_I(cfg), .REQ_I(req),
    .LOAD_DATA_I(32'hc0de_0001), .TRAP_I(trap), .IRQ_I(irq),
    .SNOOP_VALID_I(snp), .SNOOP_ADDR_I(snp_a), .WB_EMPTY_I(wbe),
    .COH_ACK_DONE_I(ack), .PEER_CLEAR_O(pclr), .PEER_CLEAR_ADDR_O(pca),
    .RSP_O(rsp), .STALL_O(stall), .DESCHED_O(dsch), .FLUSH_O(flush),
    .DI_SYNC_O(dis), .LOCK_O(lock), .SHADOW_LOCK_O(shd), .RES_ADDR_O(res));
  alr_peer_model peer (.clk_i(clk), .rst_i(rst), .flush_i(flush),
    .wb_empty_o(wbe), .ack_done_o(ack));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // one request, taken at the next rising edge
  task automatic op(input logic [2:0] o, input logic [31:0] a,
    input logic [1:0] c);
    @(negedge clk);
    req = '{1'b1, o, a, a, c[0], c[1], 1'b0, 32'h5a5a_0f0f};
    @(negedge clk);
    req.valid = 1'b0;
  endtask
  task automatic snoop(input logic [31:0] a);
    snp = 1'b1;
    snp_a = a;
    @(negedge clk);
    snp = 1'b0;
  endtask
  task automatic wait_done(output logic f);
    f = 1'b0;
    repeat (8) begin
      if (rsp.done === 1'b1) f = 1'b1;
      @(negedge clk);
    end
  endtask
  task automatic t_single;
    chk(lock, 1'b0);
    op(ALR_OP_LINKED_LOAD, 32'h1000_0040, 2'h0);
    chk(rsp.rdata, 32'hc0de_0001);
    chk(res[31:5], 27'h0);
    op(ALR_OP_STORE, 32'h1000_0040, 2'h0);
    chk(lock, 1'b1);
    op(ALR_OP_WAIT_LOCK, 32'h0, 2'h0);
    chk({rsp.done, stall, dsch}, 3'h4);
    op(ALR_OP_WRITE_BARRIER, 32'h0, 2'h0);
    chk({rsp.done, flush}, 2'h2);
  endtask
  task automatic t_mc;
    cfg = ALR_CFG_MULTI_CORE;
    op(ALR_OP_LINKED_LOAD, 32'h1000_0044, 2'h0);
    chk(res[31:5], 27'h0800002);
    op(ALR_OP_COND_STORE, 32'h2000_0000, 2'h0);
    chk({rsp.branch_val, rsp.mem_write, lock}, 3'h6);
    chk(pca, 32'h2000_0000);
    op(ALR_OP_COND_STORE, 32'h2000_0000, 2'h0);
    chk({rsp.branch_val, rsp.mem_write, lock}, 3'h0);
  endtask
  task automatic t_wait;
    op(ALR_OP_LINKED_LOAD, 32'h3000_0000, 2'h0);
    op(ALR_OP_WAIT_LOCK, 32'h0, 2'h0);
    chk(stall, 1'b1);
    snoop(32'h3000_001c);
    wait_done(d);
    chk({d, stall, lock}, 3'h4);
    cfg = ALR_CFG_MULTI_THREAD;
    op(ALR_OP_LINKED_LOAD, 32'h3000_0000, 2'h0);
    op(ALR_OP_WAIT_LOCK, 32'h0, 2'h0);
    chk(dsch, 1'b1);
    irq = 1'b1;
    wait_done(d);
    irq = 1'b0;
    chk({d, dsch}, 2'h2);
    op(ALR_OP_STORE, 32'h3000_0008, 2'h0);
    chk({pclr[0], lock}, 2'h3);
  endtask
  task automatic t_ctrl;
    op(ALR_OP_LINKED_LOAD, 32'h0, 2'h1);
    chk({rsp.exc_violation, lock}, 2'h3);
    op(ALR_OP_STORE, 32'h0, 2'h3);
    chk({rsp.exc_violation, rsp.exc_unmapped, rsp.mem_write}, 3'h2);
    trap = 1'b1;
    @(negedge clk);
    trap = 1'b0;
    chk({lock, shd}, 2'h1);
  endtask
  task automatic t_bar;
    cfg = ALR_CFG_MULTI_CORE;
    op(ALR_OP_WRITE_BARRIER, 32'h0, 2'h0);
    chk({stall, flush}, 2'h3);
    wait_done(d);
    chk({d, stall}, 2'h2);
    cfg = ALR_CFG_MULTI_THREAD;
    op(ALR_OP_DI_BARRIER, 32'h0, 2'h0);
    chk(dis, 1'b1);
    wait_done(d);
    chk({d, dis}, 2'h2);
  endtask
  task automatic print_verdict;
    if (err_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_single;
    t_mc;
    t_wait;
    t_ctrl;
    t_bar;
    print_verdict;
  end
  // watchdog
  initial begin
    #500000;
    err_count++;
    print_verdict;
  end
endmodule // test_alr_unit
bind alr_unit alr_checker u_chk (.*);
